// >>> hdl/adc_port_defines.svh
// Timing counts, field positions and reset values for the converter port.
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// System clock rate.
`define CLOCK_MHZ          100

// Conversion times, in nanoseconds, and the cycle counts derived from them.
`define CONV_ANALOG_NS     9000
`define CONV_TEMP_NS       27000
`define CONV_ANALOG_CYC    ((`CONV_ANALOG_NS * `CLOCK_MHZ + 999) / 1000)
`define CONV_TEMP_CYC      ((`CONV_TEMP_NS * `CLOCK_MHZ + 999) / 1000)
`define CONV_COUNT_W       12

// Result and control byte layout.
`define RESULT_BITS        10
`define CONTROL_BITS       8
`define CHANNEL_MSB        7
`define CHANNEL_LSB        5
`define TEMP_CHANNEL       3'h0
`define CONTROL_RESET      8'h00
`define WRITE_COUNT_W      4
`define WRITE_DONE         4'h8

// Number of pins passed through the synchroniser.
`define PIN_COUNT          7

`endif

// >>> hdl/adc_port_pkg.sv
// Types shared by the converter control and serial port logic.
package adc_port_pkg;

  typedef enum logic [1:0] {
    conv_idle,
    conv_running,
    conv_powered_down
  } conv_state_type;

endpackage : adc_port_pkg

// >>> hdl/pin_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of pins.
`timescale 1ns/1ps

module pin_sync_edge #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Pins from outside the clock domain
  input  wire logic [WIDTH-1:0] pin_async,
  // Synchronised level and one-cycle edge pulses
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] last_reg;

  // The first stage feeds only the second; edges are taken one stage later.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg   <= '0;
      stable_reg <= '0;
      last_reg   <= '0;
    end else begin
      meta_reg   <= pin_async;
      stable_reg <= meta_reg;
      last_reg   <= stable_reg;
    end
  end

  assign level = stable_reg;
  assign rise  = stable_reg & ~last_reg;
  assign fall  = ~stable_reg & last_reg;

endmodule : pin_sync_edge

// >>> hdl/adc_convert_serial_port.sv
// Conversion control and slave serial port of the converter.
`timescale 1ns/1ps
`include "adc_port_defines.svh"

// Function
// R1: Mode chosen by start level at conversion end.
// R2: Normal mode: host waits 100 ns after reads.
// R3: Held-low start powers down as busy falls.
// R4: Start rising edge powers device back up.
// R5: Host holds start low for 2 us power-up.
// R6: Slave port shifts only on host shift clock.
// R7: Select low writes control, high reads result.
// R8: Five-wire read: MSB on select rise, shift falling.
// R9: Ten bits MSB first, eight allowed.
// R10: Select stays high through split reads.
// R11: Select low then high before next read.
// R12: Five-wire output releases on select or chip-select end.
// R13: First eight rising clocks load control byte.
// R14: Five-wire: select high then low before rewrite.
// R15: Three-wire use: chip select tied, data joined.
// R16: Three-wire read: shifting starts second falling edge.
// R17: Three-wire pin turns input on select fall.
// R18: Three-wire: select high then low before rewrite.
// R19: Start falling edge holds, converts, 9/27 us busy.
// R20: Channel zero temperature sensor selected after reset.
// R21: Result loaded at conversion end, held until next.
module adc_convert_serial_port
  import adc_port_pkg::*;
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Conversion control pins
  input  wire logic                        conversion_start_n,
  output logic                             busy,
  output logic                             sample_hold,
  output logic                             powered_down,
  // Converter core
  input  wire logic [`RESULT_BITS-1:0]     analog_result,
  output logic      [2:0]                  channel_address,
  output logic      [`CONTROL_BITS-1:0]    control_byte,
  // Serial port pins
  input  wire logic                        three_wire_mode,
  input  wire logic                        read_write_select,
  input  wire logic                        device_select_n,
  input  wire logic                        shift_clock,
  input  wire logic                        serial_in,
  output logic                             serial_out,
  output logic                             serial_out_oe,
  input  wire logic                        serial_io_in,
  output logic                             serial_io_out,
  output logic                             serial_io_oe
);

  localparam logic [`CONV_COUNT_W-1:0] ANALOG_CYC =
    `CONV_COUNT_W'(`CONV_ANALOG_CYC);
  localparam logic [`CONV_COUNT_W-1:0] TEMP_CYC =
    `CONV_COUNT_W'(`CONV_TEMP_CYC);

  // Synchronised pins.
  logic [`PIN_COUNT-1:0] pin_level;
  logic [`PIN_COUNT-1:0] pin_rise;
  logic [`PIN_COUNT-1:0] pin_fall;

  pin_sync_edge #(
    .WIDTH(`PIN_COUNT)
  ) pins (
    .clock    (clock),
    .rst      (rst),
    .pin_async({three_wire_mode, serial_io_in, serial_in, shift_clock,
                device_select_n, read_write_select, conversion_start_n}),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  logic start_level;
  logic start_rise;
  logic start_fall;
  logic rw_level;
  logic rw_rise;
  logic rw_fall;
  logic select_n_level;
  logic select_n_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic three_level;
  logic data_in;
  logic select_active;

  assign start_level    = pin_level[0];
  assign start_rise     = pin_rise[0];
  assign start_fall     = pin_fall[0];
  assign rw_level       = pin_level[1];
  assign rw_rise        = pin_rise[1];
  assign rw_fall        = pin_fall[1];
  assign select_n_level = pin_level[2];
  assign select_n_rise  = pin_rise[2];
  assign sclk_rise      = pin_rise[3];
  assign sclk_fall      = pin_fall[3];
  assign three_level    = pin_level[6];
  // The three-wire hookup ties chip select low, so it is not consulted.
  assign select_active  = three_level || !select_n_level;  // see R15
  assign data_in        = three_level ? pin_level[5] : pin_level[4];

  // Conversion sequencer state.
  conv_state_type                 conv_state_reg;
  conv_state_type                 conv_state_next;
  logic [`CONV_COUNT_W-1:0]       conv_count_reg;
  logic [`CONV_COUNT_W-1:0]       conv_count_next;
  logic                           temp_conv_reg;
  logic                           temp_conv_next;
  logic [`RESULT_BITS-1:0]        result_reg;
  logic [`RESULT_BITS-1:0]        result_next;

  always_comb begin
    conv_state_next = conv_state_reg;
    conv_count_next = conv_count_reg;
    temp_conv_next  = temp_conv_reg;
    result_next     = result_reg;
    unique case (conv_state_reg)
      conv_idle: begin
        if (start_fall) begin
          // The temperature channel needs the longer conversion.
          temp_conv_next  = (channel_address == `TEMP_CHANNEL);  // see R19
          conv_count_next = (channel_address == `TEMP_CHANNEL) ?
                            TEMP_CYC - 1'b1 : ANALOG_CYC - 1'b1;
          conv_state_next = conv_running;  // see R19
        end
      end
      conv_running: begin
        if (conv_count_reg == '0) begin
          result_next = analog_result;  // see R21
          // A start line still low at the end selects power-down.
          if (!start_level) begin
            conv_state_next = conv_powered_down;  // see R1, R3
          end else begin
            conv_state_next = conv_idle;  // see R1
          end
        end else begin
          conv_count_next = conv_count_reg - 1'b1;
        end
      end
      conv_powered_down: begin
        if (start_rise) begin
          conv_state_next = conv_idle;  // see R4
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conv_state_reg <= conv_idle;
      conv_count_reg <= '0;
      temp_conv_reg  <= 1'b0;
      result_reg     <= '0;
    end else begin
      conv_state_reg <= conv_state_next;
      conv_count_reg <= conv_count_next;
      temp_conv_reg  <= temp_conv_next;
      result_reg     <= result_next;
    end
  end

  assign busy         = (conv_state_reg == conv_running);
  assign sample_hold  = (conv_state_reg == conv_running);  // see R19
  assign powered_down = (conv_state_reg == conv_powered_down);

  // Serial port state.
  logic                           read_active_reg;
  logic                           read_active_next;
  logic [`RESULT_BITS-1:0]        shift_reg;
  logic [`RESULT_BITS-1:0]        shift_next;
  logic                           out_bit_reg;
  logic                           out_bit_next;
  logic                           skip_reg;
  logic                           skip_next;
  logic [`WRITE_COUNT_W-1:0]      write_count_reg;
  logic [`WRITE_COUNT_W-1:0]      write_count_next;
  logic [`CONTROL_BITS-1:0]       write_shift_reg;
  logic [`CONTROL_BITS-1:0]       write_shift_next;
  logic [`CONTROL_BITS-1:0]       control_reg;
  logic [`CONTROL_BITS-1:0]       control_next;

  always_comb begin
    read_active_next = read_active_reg;
    shift_next       = shift_reg;
    out_bit_next     = out_bit_reg;
    skip_next        = skip_reg;
    write_count_next = write_count_reg;
    write_shift_next = write_shift_reg;
    control_next     = control_reg;

    // Reads start only on a fresh rise of the select line.
    if (rw_rise && select_active) begin
      read_active_next = 1'b1;  // see R7, R11
      shift_next       = result_reg;
      out_bit_next     = result_reg[`RESULT_BITS-1];  // see R8, R16
      // The shared pin holds its first bit past one extra falling edge.
      skip_next        = three_level;  // see R16
    end else if (read_active_reg) begin
      if (rw_fall || (!three_level && select_n_rise)) begin
        read_active_next = 1'b0;  // see R12, R17
      end else if (sclk_fall) begin
        if (skip_reg) begin
          skip_next = 1'b0;  // see R16
        end else begin
          // Bits past the tenth shift out as zero.
          shift_next   = {shift_reg[`RESULT_BITS-2:0], 1'b0};  // see R9
          out_bit_next = shift_reg[`RESULT_BITS-2];  // see R8
        end
      end
    end

    // A write window reopens only when the select line falls again.
    if (rw_fall) begin
      write_count_next = '0;  // see R14, R18
    end else if (!rw_level && select_active && sclk_rise &&
                 write_count_reg != `WRITE_DONE) begin
      write_shift_next = {write_shift_reg[`CONTROL_BITS-2:0], data_in};
      write_count_next = write_count_reg + 1'b1;  // see R6, R13
      if (write_count_reg == `WRITE_DONE - 1'b1) begin
        control_next = {write_shift_reg[`CONTROL_BITS-2:0], data_in};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      read_active_reg <= 1'b0;
      shift_reg       <= '0;
      out_bit_reg     <= 1'b0;
      skip_reg        <= 1'b0;
      write_count_reg <= '0;
      write_shift_reg <= '0;
      control_reg     <= `CONTROL_RESET;  // see R20
    end else begin
      read_active_reg <= read_active_next;
      shift_reg       <= shift_next;
      out_bit_reg     <= out_bit_next;
      skip_reg        <= skip_next;
      write_count_reg <= write_count_next;
      write_shift_reg <= write_shift_next;
      control_reg     <= control_next;
    end
  end

  assign control_byte    = control_reg;
  assign channel_address = control_reg[`CHANNEL_MSB:`CHANNEL_LSB];  // see R20
  assign serial_out      = out_bit_reg;
  assign serial_io_out   = out_bit_reg;
  assign serial_out_oe   = read_active_reg && !three_level;  // see R12
  assign serial_io_oe    = read_active_reg && three_level;  // see R17

  // Checks.
  logic [`CONV_COUNT_W-1:0] busy_len_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_len_reg <= '0;
    end else if (busy) begin
      busy_len_reg <= busy_len_reg + 1'b1;
    end else begin
      busy_len_reg <= '0;
    end
  end

  default clocking chk_clock @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence conv_request;
    conv_state_reg == conv_idle && start_fall;
  endsequence

  sequence conv_end_low;
    busy ##1 !busy && $past(!start_level);
  endsequence

  sequence read_open;
    rw_rise && select_active;
  endsequence

  sequence read_shift_fall;
    sclk_fall && read_active_reg && !skip_reg && !rw_fall &&
      !(select_n_rise && !three_level);
  endsequence

  chk_busy_start: assert property ( // see R19
    conv_request |=> busy && sample_hold
  ) else $error("busy did not rise after start fall");

  chk_busy_length: assert property ( // see R19
    $fell(busy) |-> busy_len_reg == (temp_conv_reg ? TEMP_CYC : ANALOG_CYC)
  ) else $error("conversion length wrong");

  chk_auto_powerdown: assert property ( // see R3
    conv_end_low |-> powered_down
  ) else $error("no power-down with start held low");

  chk_normal_mode: assert property ( // see R1
    $fell(busy) && $past(start_level) |-> conv_state_reg == conv_idle
  ) else $error("normal mode entered power-down");

  chk_power_up: assert property ( // see R4
    powered_down && start_rise |=> !powered_down
  ) else $error("no power-up on start rise");

  chk_result_hold: assert property ( // see R21
    $fell(busy) |-> result_reg == $past(analog_result)
  ) else $error("result not loaded at conversion end");

  chk_result_stable: assert property ( // see R21
    !busy ##1 !busy |-> $stable(result_reg)
  ) else $error("result changed between conversions");

  chk_msb_first: assert property ( // see R8, R16
    read_open |=> read_active_reg &&
      out_bit_reg == $past(result_reg[`RESULT_BITS-1])
  ) else $error("first read bit is not the msb");

  chk_five_shift: assert property ( // see R8, R16
    read_shift_fall |=> out_bit_reg == $past(shift_reg[`RESULT_BITS-2])
  ) else $error("read did not shift on falling edge");

  chk_release_out: assert property ( // see R12, R17
    read_active_reg && (rw_fall || (!three_level && select_n_rise)) |=>
      !serial_out_oe && !serial_io_oe
  ) else $error("data pin not released at read end");

  chk_write_ignore: assert property ( // see R13
    write_count_reg == `WRITE_DONE && !rw_fall |=> $stable(control_reg)
  ) else $error("control byte changed after eight clocks");

  chk_slave_shift: assert property ( // see R6
    !sclk_rise |=> $stable(write_shift_reg)
  ) else $error("write shifted without a clock edge");

endmodule : adc_convert_serial_port

// >>> verif/host_port_model.sv
// Host model that drives the converter's control and serial pins.
`timescale 1ns/1ps

module host_port_model (
  // Clock
  input  wire logic clock,
  // Interface variant and the level on the host's receive line
  input  wire logic three_wire,
  input  wire logic data_in,
  // Pins driven by the host
  output logic      conversion_start_n,
  output logic      read_write_select,
  output logic      device_select_n,
  output logic      shift_clock,
  output logic      data_out,
  output logic      data_oe
);
  // The shift clock idles high and only moves inside a transfer.
  initial begin
    conversion_start_n = 1'b1;
    read_write_select  = 1'b0;
    device_select_n    = 1'b1;
    shift_clock        = 1'b1;
    data_out           = 1'b0;
    data_oe            = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One shift clock cycle of 80 ns, falling half first.
  task automatic shift_cycle();
    shift_clock <= ~shift_clock;
    tick(4);
    shift_clock <= ~shift_clock;
    tick(4);
  endtask : shift_cycle

  task automatic set_start(input logic level);
    conversion_start_n <= level;
  endtask : set_start

  task automatic write_byte(input logic [7:0] value, input int clocks,
                            input logic reopen);
    logic [7:0] shifter;
    int         i;
    shifter = value;
    read_write_select <= 1'b0;
    device_select_n   <= 1'b0;
    tick(6);
    for (i = 0; i < clocks; i++) begin
      data_oe  <= 1'b1;
      data_out <= shifter[7];
      shifter = {shifter[6:0], ~shifter[7]};
      shift_cycle();
    end
    // A released line does not keep its last level.
    data_oe         <= 1'b0;
    data_out        <= ~data_out;
    device_select_n <= 1'b1;
    tick(6);
    if (reopen) begin
      read_write_select <= 1'b1;
      tick(6);
    end
  endtask : write_byte

  task automatic read_bits(input int bits, input logic by_select,
                           output logic [9:0] value);
    int i;
    value = '0;
    read_write_select <= 1'b0;
    device_select_n   <= 1'b0;
    tick(6);
    read_write_select <= 1'b1;
    tick(6);
    if (three_wire) begin
      shift_cycle();
    end
    for (i = 0; i < bits; i++) begin
      if (i > 0) begin
        shift_cycle();
      end
      value = {value[8:0], data_in};
    end
    // Ending by chip select leaves the select line high, and vice versa.
    device_select_n   <= by_select;
    read_write_select <= by_select;
    tick(6);
    device_select_n   <= 1'b1;
    read_write_select <= 1'b0;
    tick(6);
  endtask : read_bits
endmodule : host_port_model

// >>> verif/test_adc_convert_serial_port.sv
// Self-checking testbench for the converter control and serial port.
`timescale 1ns/1ps
`include "adc_port_defines.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  failures++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
  end end

module test_adc_convert_serial_port;
  import adc_port_pkg::*;

  typedef struct {
    logic       three;
    logic [7:0] ctrl;
    logic [9:0] res;
    int         cyc;
  } case_type;

  logic                       clock;
  logic                       rst;
  logic                       three_wire_mode;
  logic [`RESULT_BITS-1:0]    analog_result;
  logic                       conversion_start_n;
  logic                       read_write_select;
  logic                       device_select_n;
  logic                       shift_clock;
  logic                       host_data;
  logic                       host_oe;
  logic                       busy;
  logic                       sample_hold;
  logic                       powered_down;
  logic [2:0]                 channel_address;
  logic [`CONTROL_BITS-1:0]   control_byte;
  logic                       serial_out;
  logic                       serial_out_oe;
  logic                       serial_io_out;
  logic                       serial_io_oe;
  logic                       io_wire;
  logic                       host_rx;
  int                         failures;
  int                         checks;
  int                         n;
  case_type                   rows [4];
  logic [9:0]                 got;

  // Undriven lines show the inverse of the last bit, not a kind value.
  assign io_wire = serial_io_oe ? serial_io_out
                 : (host_oe ? host_data : ~serial_io_out);
  assign host_rx = three_wire_mode ? io_wire
                 : (serial_out_oe ? serial_out : ~serial_out);

  initial clock = 1'b0;
  always #5 clock = ~clock;

  adc_convert_serial_port dut (
    .clock(clock), .rst(rst), .conversion_start_n(conversion_start_n),
    .busy(busy), .sample_hold(sample_hold), .powered_down(powered_down),
    .analog_result(analog_result), .channel_address(channel_address),
    .control_byte(control_byte), .three_wire_mode(three_wire_mode),
    .read_write_select(read_write_select),
    .device_select_n(device_select_n), .shift_clock(shift_clock),
    .serial_in(host_data), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .serial_io_in(io_wire),
    .serial_io_out(serial_io_out), .serial_io_oe(serial_io_oe)
  );

  host_port_model host (
    .clock(clock), .three_wire(three_wire_mode), .data_in(host_rx),
    .conversion_start_n(conversion_start_n),
    .read_write_select(read_write_select),
    .device_select_n(device_select_n), .shift_clock(shift_clock),
    .data_out(host_data), .data_oe(host_oe)
  );

  task automatic report_and_stop();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Starts a conversion and counts the cycles for which busy stands.
  task automatic convert(input logic hold, output int cycles);
    int w;
    w = 0;
    cycles = 0;
    host.set_start(1'b0);
    while (busy !== 1'b1 && w < 10) begin
      @(posedge clock);
      w++;
    end
    `CHK(sample_hold, 1'b1)
    while (busy === 1'b1 && cycles < 3000) begin
      @(posedge clock);
      cycles++;
      if (cycles == 200 && !hold) begin
        host.set_start(1'b1);
      end
    end
  endtask : convert

  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    report_and_stop();
  end

  initial begin
    rst             = 1'b1;
    three_wire_mode = 1'b0;
    analog_result   = '0;
    failures        = 0;
    checks          = 0;
    rows = '{'{1'b0, 8'h20, 10'h2a5, `CONV_ANALOG_CYC},
             '{1'b0, 8'h00, 10'h15a, `CONV_TEMP_CYC},
             '{1'b1, 8'h40, 10'h3c3, `CONV_ANALOG_CYC},
             '{1'b1, 8'hff, 10'h001, `CONV_ANALOG_CYC}};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(busy, 1'b0)
    `CHK(powered_down, 1'b0)
    `CHK(control_byte, `CONTROL_RESET)
    `CHK(channel_address, `TEMP_CHANNEL)
    `CHK({serial_out_oe, serial_io_oe}, 2'b00)
    foreach (rows[i]) begin
      three_wire_mode <= rows[i].three;
      host.tick(4);
      host.write_byte(rows[i].ctrl, 8, 1'b1);
      `CHK(control_byte, rows[i].ctrl)
      // Reopening with chip select high starts a read only on three wires.
      `CHK({serial_out_oe, serial_io_oe}, {1'b0, rows[i].three})
      `CHK(channel_address, rows[i].ctrl[7:5])
      analog_result <= rows[i].res;
      convert(1'b0, n);
      `CHK(n, rows[i].cyc)
      `CHK(powered_down, 1'b0)
      // The core value moves on; the held result must not.
      analog_result <= ~rows[i].res;
      host.read_bits(10, 1'b0, got);
      `CHK(got, rows[i].res)
      `CHK({serial_out_oe, serial_io_oe}, 2'b00)
    end
    three_wire_mode <= 1'b0;
    host.tick(4);
    // Clocks beyond the eighth and a write without reopening are ignored.
    host.write_byte(8'ha5, 10, 1'b0);
    `CHK(control_byte, 8'ha5)
    host.write_byte(8'h3c, 8, 1'b1);
    `CHK(control_byte, 8'ha5)
    host.write_byte(8'h3c, 8, 1'b1);
    `CHK(control_byte, 8'h3c)
    analog_result <= 10'h1e7;
    convert(1'b1, n);
    `CHK(n, `CONV_ANALOG_CYC)
    `CHK(powered_down, 1'b1)
    host.tick(20);
    `CHK(powered_down, 1'b1)
    host.set_start(1'b1);
    host.tick(6);
    `CHK(powered_down, 1'b0)
    host.read_bits(8, 1'b1, got);
    `CHK(got[7:0], 8'h79)
    `CHK(serial_out_oe, 1'b0)
    report_and_stop();
  end
endmodule : test_adc_convert_serial_port
